/* File: design/dmacc_pkg.sv */
// Constants, register map and state encodings of the DMA channel controller.
// Assumes a single clock domain and a 32-bit AHB-Lite register bus.
`default_nettype none
package dmacc_pkg;
	localparam int NCH = 2;
	localparam int CHW = $clog2(NCH);
	localparam int AW = 16;
	////////////////////////////////////////////////////////////////
	// Register map: channel windows, then a global window
	localparam int CH_SH = 5;
	localparam int CHF_W = 3;
	localparam int GLOB_BIT = 8;
	localparam int ADDR_W = 9;
	localparam logic [2:0] R_CTRL = 3'h0;
	localparam logic [2:0] R_SA = 3'h1;
	localparam logic [2:0] R_SB = 3'h2;
	localparam logic [2:0] R_PA = 3'h3;
	localparam logic [2:0] R_CNT = 3'h4;
	localparam logic [2:0] R_SWREQ = 3'h5;
	localparam logic [2:0] R_STAT = 3'h6;
	localparam logic [2:0] G_LAST = 3'h0;
	localparam logic [2:0] G_IST = 3'h1;
	localparam logic [2:0] G_IMASK = 3'h2;
	////////////////////////////////////////////////////////////////
	// Control register fields
	localparam int B_EN = 15;
	localparam int B_SIZE = 14;
	localparam int B_DIR = 13;
	localparam int B_HALF = 12;
	localparam int B_NULL = 11;
	localparam int AM_LO = 4;
	localparam int OM_LO = 0;
	localparam int B_SWREQ = 0;
	localparam logic [15:0] CTRL_WMASK = 16'hf833;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] REG_RST = 16'h0000;
	localparam logic [15:0] NULL_DATA = 16'h0000;
	typedef enum logic [1:0] {AM_INC = 2'b00, AM_FIX = 2'b01, AM_PER = 2'b10, AM_RSV = 2'b11} dmacc_am_e;
	typedef enum logic [1:0] {OM_CONT = 2'b00, OM_ONE = 2'b01, OM_CONT_PP = 2'b10, OM_ONE_PP = 2'b11} dmacc_om_e;
	typedef enum logic [1:0] {E_IDLE = 2'b00, E_READ = 2'b01, E_CAP = 2'b10, E_WRITE = 2'b11} dmacc_eng_e;
endpackage
`default_nettype wire

/* File: design/dmacc_chan.sv */
// One DMA channel: its registers, request flag, block counter and address.
// Assumes the engine pulses step once per finished transfer of this channel.
`default_nettype none
module dmacc_chan (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [2:0] wr_reg,
	input wire logic [15:0] wdata,
	input wire logic per_req,
	input wire logic step,
	input wire logic [15:0] per_ind_addr,
	output logic [15:0] ctrl,
	output logic [15:0] sa,
	output logic [15:0] sb,
	output logic [15:0] pa,
	output logic [15:0] cnt,
	output logic pend,
	output logic pp,
	output logic [15:0] ram_addr,
	output logic blk_evt
);
	logic [15:0] idx;
	logic en, last, half_hit, stop;
	logic [15:0] base;
	logic [1:0] am, om;

	assign en = ctrl[dmacc_pkg::B_EN];
	assign am = ctrl[dmacc_pkg::AM_LO +: 2];
	assign om = ctrl[dmacc_pkg::OM_LO +: 2];
	assign last = idx == cnt;
	assign half_hit = 16'(idx + 16'h0001) == 16'((cnt >> 1) + 16'h0001);
	assign stop = last && (om == dmacc_pkg::OM_ONE || (om == dmacc_pkg::OM_ONE_PP && pp));
	assign blk_evt = step && (ctrl[dmacc_pkg::B_HALF] ? half_hit : last);
	assign base = pp ? sb : sa;

	always_comb begin
		case (am)
			dmacc_pkg::AM_INC: ram_addr = ctrl[dmacc_pkg::B_SIZE] ? 16'(base + idx) : 16'(base + (idx << 1));
			dmacc_pkg::AM_FIX: ram_addr = base;
			default: ram_addr = 16'(base + per_ind_addr);
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl <= dmacc_pkg::CTRL_RST;
		end else if (wr_en && wr_reg == dmacc_pkg::R_CTRL) begin
			ctrl <= wdata & dmacc_pkg::CTRL_WMASK;
		end else if (step && stop) begin
			ctrl[dmacc_pkg::B_EN] <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sa <= dmacc_pkg::REG_RST;
			sb <= dmacc_pkg::REG_RST;
			pa <= dmacc_pkg::REG_RST;
			cnt <= dmacc_pkg::REG_RST;
		end else if (wr_en) begin
			if (wr_reg == dmacc_pkg::R_SA) sa <= wdata;
			if (wr_reg == dmacc_pkg::R_SB) sb <= wdata;
			if (wr_reg == dmacc_pkg::R_PA) pa <= wdata;
			if (wr_reg == dmacc_pkg::R_CNT) cnt <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !en) begin
			idx <= 16'h0000;
			pp <= 1'b0;
		end else if (step) begin
			idx <= last ? 16'h0000 : 16'(idx + 16'h0001);
			if (last && om[1]) pp <= ~pp;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !en) begin
			pend <= 1'b0;
		end else if (per_req || (wr_en && wr_reg == dmacc_pkg::R_SWREQ && wdata[dmacc_pkg::B_SWREQ])) begin
			pend <= 1'b1;
		end else if (step) begin
			pend <= 1'b0;
		end
	end

	chk_ctrl_mask: assert property (@(posedge clk) disable iff (rst) (ctrl & ~dmacc_pkg::CTRL_WMASK) == 16'h0000)
		else $error("unimplemented control bit set");
	chk_oneshot_stop: assert property (@(posedge clk) disable iff (rst)
		step && stop && !wr_en |=> !en)
		else $error("one-shot channel not stopped");
	chk_fixed_addr: assert property (@(posedge clk) disable iff (rst)
		am == dmacc_pkg::AM_FIX && !pp |-> ram_addr == sa)
		else $error("fixed address moved");
	chk_pp_swap: assert property (@(posedge clk) disable iff (rst)
		step && last && om[1] && en && !(wr_en && wr_reg == dmacc_pkg::R_CTRL) |=> pp != $past(pp))
		else $error("ping-pong buffer not swapped");
endmodule
`default_nettype wire

/* File: design/dmacc_top.sv */
// DMA channel controller: AHB-Lite register slave, channels, arbiter, engine.
// Assumes buffer RAM and peripheral ports answer reads one cycle after the strobe.
`default_nettype none
module dmacc_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [dmacc_pkg::NCH-1:0] per_req,
	input wire logic [15:0] per_ind_addr,
	output logic [15:0] ram_addr,
	output logic [1:0] ram_be,
	output logic ram_re,
	output logic ram_we,
	output logic [15:0] ram_wdata,
	input wire logic [15:0] ram_rdata,
	output logic [15:0] per_addr,
	output logic [1:0] per_be,
	output logic per_re,
	output logic per_we,
	output logic [15:0] per_wdata,
	input wire logic [15:0] per_rdata,
	output logic irq
);
	localparam int NCH = dmacc_pkg::NCH;
	localparam int CHW = dmacc_pkg::CHW;

	logic [15:0] ctrl_a [NCH];
	logic [15:0] sa_a [NCH];
	logic [15:0] sb_a [NCH];
	logic [15:0] pa_a [NCH];
	logic [15:0] cnt_a [NCH];
	logic [15:0] caddr_a [NCH];
	logic [NCH-1:0] pend, pp, evt, step, ch_wr;
	logic [NCH-1:0] ist, imask, next_ist;
	logic [15:0] last_addr;

	logic a_wr, a_rd;
	logic [dmacc_pkg::ADDR_W-1:0] a_addr;
	logic [2:0] a_reg;
	logic [dmacc_pkg::CHF_W-1:0] a_ch;
	logic a_glob, a_chok;
	logic [15:0] rd_val;

	dmacc_pkg::dmacc_eng_e state;
	logic [CHW-1:0] gch, pick;
	logic any_pend;
	logic tr_dir, tr_size, tr_null;
	logic [15:0] tr_ram, tr_per, dbuf;

	////////////////////////////////////////////////////////////////
	// AHB-Lite slave: writes take no wait, reads one wait state
	assign hresp = 1'b0;
	assign hreadyout = !a_rd;
	assign a_reg = a_addr[4:2];
	assign a_ch = a_addr[dmacc_pkg::CH_SH +: dmacc_pkg::CHF_W];
	assign a_glob = a_addr[dmacc_pkg::GLOB_BIT];
	assign a_chok = !a_glob && a_ch < dmacc_pkg::CHF_W'(NCH);

	always_ff @(posedge clk) begin
		if (rst) begin
			a_wr <= 1'b0;
			a_rd <= 1'b0;
			a_addr <= '0;
		end else if (hreadyout) begin
			a_wr <= hsel && htrans[1] && hready && hwrite;
			a_rd <= hsel && htrans[1] && hready && !hwrite;
			if (hsel && htrans[1] && hready) a_addr <= haddr[dmacc_pkg::ADDR_W-1:0];
		end else begin
			a_wr <= 1'b0;
			a_rd <= 1'b0;
		end
	end

	always_comb begin
		rd_val = 16'h0000;
		if (a_glob) begin
			case (a_reg)
				dmacc_pkg::G_LAST: rd_val = last_addr;
				dmacc_pkg::G_IST: rd_val = 16'(ist);
				dmacc_pkg::G_IMASK: rd_val = 16'(imask);
				default: rd_val = 16'h0000;
			endcase
		end else if (a_chok) begin
			case (a_reg)
				dmacc_pkg::R_CTRL: rd_val = ctrl_a[a_ch[CHW-1:0]];
				dmacc_pkg::R_SA: rd_val = sa_a[a_ch[CHW-1:0]];
				dmacc_pkg::R_SB: rd_val = sb_a[a_ch[CHW-1:0]];
				dmacc_pkg::R_PA: rd_val = pa_a[a_ch[CHW-1:0]];
				dmacc_pkg::R_CNT: rd_val = cnt_a[a_ch[CHW-1:0]];
				dmacc_pkg::R_STAT: rd_val = {14'h0000, pp[a_ch[CHW-1:0]], pend[a_ch[CHW-1:0]]};
				default: rd_val = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) hrdata <= 32'h00000000;
		else if (a_rd) hrdata <= {16'h0000, rd_val};
	end

	////////////////////////////////////////////////////////////////
	// Channels
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		assign ch_wr[i] = a_wr && a_chok && a_ch == dmacc_pkg::CHF_W'(i);
		assign step[i] = state == dmacc_pkg::E_WRITE && gch == CHW'(i);
		dmacc_chan u_chan (
			.clk(clk),
			.rst(rst),
			.wr_en(ch_wr[i]),
			.wr_reg(a_reg),
			.wdata(hwdata[15:0]),
			.per_req(per_req[i]),
			.step(step[i]),
			.per_ind_addr(per_ind_addr),
			.ctrl(ctrl_a[i]),
			.sa(sa_a[i]),
			.sb(sb_a[i]),
			.pa(pa_a[i]),
			.cnt(cnt_a[i]),
			.pend(pend[i]),
			.pp(pp[i]),
			.ram_addr(caddr_a[i]),
			.blk_evt(evt[i])
		);
	end

	////////////////////////////////////////////////////////////////
	// Interrupt status, write one to clear, set wins
	always_comb begin
		next_ist = ist;
		if (a_wr && a_glob && a_reg == dmacc_pkg::G_IST) next_ist = ist & ~hwdata[NCH-1:0];
		next_ist = next_ist | evt;
	end

	always_ff @(posedge clk) begin
		if (rst) ist <= '0;
		else ist <= next_ist;
	end

	always_ff @(posedge clk) begin
		if (rst) imask <= '0;
		else if (a_wr && a_glob && a_reg == dmacc_pkg::G_IMASK) imask <= hwdata[NCH-1:0];
	end

	assign irq = |(ist & imask);

	////////////////////////////////////////////////////////////////
	// Fixed priority: lowest channel number wins
	always_comb begin
		pick = '0;
		any_pend = 1'b0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (pend[i] && ctrl_a[i][dmacc_pkg::B_EN]) begin
				pick = CHW'(i);
				any_pend = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Transfer engine
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= dmacc_pkg::E_IDLE;
			gch <= '0;
		end else begin
			case (state)
				dmacc_pkg::E_IDLE: begin
					if (any_pend) begin
						state <= dmacc_pkg::E_READ;
						gch <= pick;
					end
				end
				dmacc_pkg::E_READ: state <= dmacc_pkg::E_CAP;
				dmacc_pkg::E_CAP: state <= dmacc_pkg::E_WRITE;
				dmacc_pkg::E_WRITE: state <= dmacc_pkg::E_IDLE;
				default: state <= dmacc_pkg::E_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tr_dir <= 1'b0;
			tr_size <= 1'b0;
			tr_null <= 1'b0;
			tr_ram <= 16'h0000;
			tr_per <= 16'h0000;
		end else if (state == dmacc_pkg::E_IDLE && any_pend) begin
			tr_dir <= ctrl_a[pick][dmacc_pkg::B_DIR];
			tr_size <= ctrl_a[pick][dmacc_pkg::B_SIZE];
			tr_null <= ctrl_a[pick][dmacc_pkg::B_NULL];
			tr_ram <= caddr_a[pick];
			tr_per <= pa_a[pick];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ram_re <= 1'b0;
			per_re <= 1'b0;
		end else begin
			ram_re <= state == dmacc_pkg::E_IDLE && any_pend && ctrl_a[pick][dmacc_pkg::B_DIR];
			per_re <= state == dmacc_pkg::E_IDLE && any_pend && !ctrl_a[pick][dmacc_pkg::B_DIR];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ram_we <= 1'b0;
			per_we <= 1'b0;
		end else begin
			ram_we <= state == dmacc_pkg::E_CAP && !tr_dir;
			per_we <= state == dmacc_pkg::E_CAP && (tr_dir || tr_null);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ram_addr <= 16'h0000;
			per_addr <= 16'h0000;
			ram_be <= 2'b00;
			per_be <= 2'b00;
		end else if (state == dmacc_pkg::E_IDLE && any_pend) begin
			ram_addr <= caddr_a[pick];
			per_addr <= pa_a[pick];
			ram_be <= ctrl_a[pick][dmacc_pkg::B_SIZE] ? (caddr_a[pick][0] ? 2'b10 : 2'b01) : 2'b11;
			per_be <= ctrl_a[pick][dmacc_pkg::B_SIZE] ? (pa_a[pick][0] ? 2'b10 : 2'b01) : 2'b11;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dbuf <= 16'h0000;
		end else if (state == dmacc_pkg::E_CAP) begin
			if (!tr_size) dbuf <= tr_dir ? ram_rdata : per_rdata;
			else if (tr_dir) dbuf <= tr_ram[0] ? {2{ram_rdata[15:8]}} : {2{ram_rdata[7:0]}};
			else dbuf <= tr_per[0] ? {2{per_rdata[15:8]}} : {2{per_rdata[7:0]}};
		end
	end

	assign ram_wdata = dbuf;
	assign per_wdata = tr_dir ? dbuf : dmacc_pkg::NULL_DATA;

	always_ff @(posedge clk) begin
		if (rst) last_addr <= 16'h0000;
		else if (ram_re || ram_we) last_addr <= ram_addr;
	end

	////////////////////////////////////////////////////////////////
	// Checks
	chk_grant_enabled: assert property (@(posedge clk) disable iff (rst)
		state == dmacc_pkg::E_IDLE && any_pend |-> ctrl_a[pick][dmacc_pkg::B_EN])
		else $error("disabled channel granted");
	chk_byte_lane: assert property (@(posedge clk) disable iff (rst)
		(ram_we || ram_re) && tr_size |-> $onehot(ram_be))
		else $error("byte transfer drives two lanes");
	chk_word_lanes: assert property (@(posedge clk) disable iff (rst)
		(ram_we || ram_re) && !tr_size |-> ram_be == 2'b11)
		else $error("word transfer misses a ram lane");
	chk_per_lanes: assert property (@(posedge clk) disable iff (rst)
		(per_we || per_re) && !tr_size |-> per_be == 2'b11)
		else $error("word transfer misses a peripheral lane");
	chk_byte_replicate: assert property (@(posedge clk) disable iff (rst)
		per_we && tr_dir && tr_size |-> per_wdata[15:8] == per_wdata[7:0])
		else $error("byte not replicated on both lanes");
	chk_read_onehot: assert property (@(posedge clk) disable iff (rst)
		!(ram_re && per_re))
		else $error("both read strobes high");
	chk_strobe_pulse: assert property (@(posedge clk) disable iff (rst)
		ram_re || per_re |=> !ram_re && !per_re)
		else $error("read strobe longer than one cycle");
	chk_ram_addr: assert property (@(posedge clk) disable iff (rst)
		ram_re |-> ram_addr == tr_ram)
		else $error("ram read address differs from grant");
	chk_ram_read_dir: assert property (@(posedge clk) disable iff (rst)
		ram_re |-> tr_dir ##2 per_we && !ram_we)
		else $error("ram read not followed by peripheral write");
	chk_ram_write_dir: assert property (@(posedge clk) disable iff (rst)
		per_re |-> !tr_dir ##2 ram_we)
		else $error("peripheral read not followed by ram write");
	chk_per_addr: assert property (@(posedge clk) disable iff (rst)
		per_re |-> per_addr == tr_per)
		else $error("peripheral read address differs from grant");
	chk_null_write: assert property (@(posedge clk) disable iff (rst)
		ram_we && tr_null |-> per_we && per_wdata == dmacc_pkg::NULL_DATA)
		else $error("dummy peripheral write missing");
	chk_dummy_data: assert property (@(posedge clk) disable iff (rst)
		per_we && !tr_dir |-> per_wdata == dmacc_pkg::NULL_DATA)
		else $error("dummy write carries data");
	chk_last_addr: assert property (@(posedge clk) disable iff (rst)
		ram_re || ram_we |=> last_addr == $past(ram_addr))
		else $error("last ram address not updated");
	chk_fixed_prio: assert property (@(posedge clk) disable iff (rst)
		state == dmacc_pkg::E_IDLE && pend[0] && ctrl_a[0][dmacc_pkg::B_EN] |=> gch == '0 && state == dmacc_pkg::E_READ)
		else $error("channel zero not served first");
	chk_irq_sticky: assert property (@(posedge clk) disable iff (rst)
		|evt |=> (ist & $past(evt)) == $past(evt))
		else $error("block event lost");
	chk_ist_clear: assert property (@(posedge clk) disable iff (rst)
		a_wr && a_glob && a_reg == dmacc_pkg::G_IST && !(|evt) |=> (ist & $past(hwdata[NCH-1:0])) == '0)
		else $error("status bit not cleared by write one");
	chk_rd_wait: assert property (@(posedge clk) disable iff (rst)
		a_rd |-> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	chk_wr_nowait: assert property (@(posedge clk) disable iff (rst)
		a_wr |-> hreadyout)
		else $error("write data phase stalled");

	cov_ram_to_per: cover property (@(posedge clk) disable iff (rst) ram_re ##2 per_we);
	cov_per_to_ram: cover property (@(posedge clk) disable iff (rst) per_re ##2 ram_we);
	cov_both_pend: cover property (@(posedge clk) disable iff (rst) &pend && state == dmacc_pkg::E_IDLE);
	cov_irq: cover property (@(posedge clk) disable iff (rst) $rose(irq));
	cov_null_write: cover property (@(posedge clk) disable iff (rst) ram_we && per_we);
endmodule
`default_nettype wire

/* File: tb/dmacc_far_model.sv */
// Far-side model: buffer RAM and peripheral register ports.
// Assumes the controller pulses each read strobe for one cycle.
`default_nettype none
module dmacc_far_model (
	input wire logic clk,
	input wire logic [15:0] ram_addr,
	input wire logic ram_re,
	input wire logic [15:0] per_addr,
	input wire logic per_re,
	output logic [15:0] ram_rdata,
	output logic [15:0] per_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	function automatic logic [15:0] pat(input logic [15:0] a, input logic [15:0] s);
		return {a[7:0] ^ s[15:8], ~a[15:8] ^ s[7:0]};
	endfunction
	initial begin
		ram_rdata = 16'h0000;
		per_rdata = 16'h0000;
	end
	// Data valid only the cycle after a strobe, toggles otherwise
	always @(posedge clk) begin
		ram_rdata <= ram_re ? pat(ram_addr, 16'h3c00) : ~ram_rdata;
		per_rdata <= per_re ? pat(per_addr, 16'h00c3) : ~per_rdata;
	end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the DMA channel controller.
// Assumes the far-side model answers reads one cycle after each strobe.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, hsel, hwrite, hreadyout, hresp, ram_re, ram_we, per_re, per_we, irq;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic [1:0] htrans, ram_be, per_be, per_req;
	logic [15:0] per_ind_addr, ram_addr, ram_wdata, ram_rdata, per_addr, per_wdata, per_rdata;
	logic [15:0] sa, sb, pa, ea, b, wa[$], wd[$], pd[$];
	logic [1:0] pb[$];
	int error_cnt = 0, checks_done = 0, seed, n;
	dmacc_top dmacc_top_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.per_req(per_req), .per_ind_addr(per_ind_addr), .ram_addr(ram_addr), .ram_be(ram_be), .ram_re(ram_re),
		.ram_we(ram_we), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .per_addr(per_addr), .per_be(per_be),
		.per_re(per_re), .per_we(per_we), .per_wdata(per_wdata), .per_rdata(per_rdata), .irq(irq));
	dmacc_far_model dmacc_far_model_inst (.clk(clk), .ram_addr(ram_addr), .ram_re(ram_re), .per_addr(per_addr),
		.per_re(per_re), .ram_rdata(ram_rdata), .per_rdata(per_rdata));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (ram_we === 1'b1) begin
			wa.push_back(ram_addr);
			wd.push_back(ram_wdata);
		end
		if (per_we === 1'b1) begin
			pd.push_back(per_wdata);
			pb.push_back(per_be);
		end
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [15:0] pat(input logic [15:0] a, input logic [15:0] s);
		return {a[7:0] ^ s[15:8], ~a[15:8] ^ s[7:0]};
	endfunction
	function automatic logic [31:0] ra(input int ch, input logic [2:0] r);
		return 32'(ch << dmacc_pkg::CH_SH) | {27'h0, r, 2'b00};
	endfunction
	function automatic logic [31:0] ga(input logic [2:0] r);
		return 32'(1 << dmacc_pkg::GLOB_BIT) | {27'h0, r, 2'b00};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask
	task automatic setup(input int ch, input logic [15:0] c, a, bb, cn);
		bus(ra(ch, dmacc_pkg::R_CTRL), 1, 0);
		bus(ra(ch, dmacc_pkg::R_SA), 1, {16'h0, a});
		bus(ra(ch, dmacc_pkg::R_SB), 1, {16'h0, bb});
		bus(ra(ch, dmacc_pkg::R_PA), 1, {16'h0, pa});
		bus(ra(ch, dmacc_pkg::R_CNT), 1, {16'h0, cn});
		bus(ra(ch, dmacc_pkg::R_CTRL), 1, {16'h0, c});
	endtask
	task automatic xfer(input int ch, input bit to_ram);
		int n0;
		n0 = to_ram ? wa.size() : pd.size();
		bus(ra(ch, dmacc_pkg::R_SWREQ), 1, 1);
		repeat (30) if ((to_ram ? wa.size() : pd.size()) == n0) @(posedge clk);
		@(posedge clk);
		chk(to_ram ? wa.size() : pd.size(), n0 + 1);
	endtask
	task automatic end_of_test();
		$display("Checks %0d, errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		seed = $urandom(32'hc6502416);
		{hsel, hwrite, haddr, hwdata, htrans, per_req, per_ind_addr, pa} = '0;
		rst = 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		bus(ra(0, dmacc_pkg::R_CTRL), 0, 0);
		chk(rdv, 32'h0);
		bus(ga(dmacc_pkg::G_LAST), 0, 0);
		chk(rdv, 32'h0);
		chk(hresp, 1'b0);
		for (int i = 0; i < 4; i++) begin
			sa = (i == 0) ? 16'hffff : 16'($urandom);
			bus(ra(1, dmacc_pkg::R_CTRL), 1, {16'hffff, sa});
			bus(ra(1, dmacc_pkg::R_CTRL), 0, 0);
			chk(rdv, {16'h0, sa & 16'hf833});
		end
		// Every addressing style, word reads from the peripheral
		for (int am = 0; am < 4; am++) begin
			sa = 16'($urandom) & 16'h0ffe;
			pa = 16'($urandom);
			per_ind_addr <= 16'($urandom) & 16'h00fe;
			setup(0, 16'h8000 | 16'(am << 4), sa, 16'h0, 16'h1);
			ea = am[1] ? sa + per_ind_addr : sa;
			xfer(0, 1);
			chk(wa[$], ea);
			chk(wd[$], pat(pa, 16'h00c3));
			chk(per_addr, pa);
			chk(ram_be, 2'b11);
			bus(ga(dmacc_pkg::G_LAST), 0, 0);
			chk(rdv, {16'h0, ea});
			xfer(0, 1);
			if (am < 2) chk(wa[$] == sa, am == 1);
			bus(ga(dmacc_pkg::G_IST), 0, 0);
			chk(rdv, 32'h1);
			bus(ga(dmacc_pkg::G_IST), 1, 1);
		end
		bus(ra(0, dmacc_pkg::R_CTRL), 1, 0);
		n = wa.size();
		bus(ra(0, dmacc_pkg::R_SWREQ), 1, 1);
		repeat (12) @(posedge clk);
		chk(wa.size(), n);
		// Byte, buffer RAM to peripheral, one-shot
		sa = 16'($urandom);
		pa = 16'($urandom);
		setup(1, 16'he001, sa, 16'h0, 16'h0);
		xfer(1, 0);
		b = pat(sa, 16'h3c00);
		b = sa[0] ? {b[15:8], b[15:8]} : {b[7:0], b[7:0]};
		chk(pd[$], b);
		chk(pb[$], pa[0] ? 2'b10 : 2'b01);
		chk(ram_be, sa[0] ? 2'b10 : 2'b01);
		bus(ra(1, dmacc_pkg::R_CTRL), 0, 0);
		chk(rdv, 32'h6001);
		// Dummy write with direction kept clear by software
		n = pd.size();
		setup(0, 16'h8810, sa, 16'h0, 16'h3);
		xfer(0, 1);
		chk(pd.size(), n + 1);
		chk(pd[$], 16'h0000);
		// Half-block event, mask and clear
		bus(ga(dmacc_pkg::G_IST), 1, 3);
		setup(0, 16'h9010, sa, 16'h0, 16'h3);
		bus(ga(dmacc_pkg::G_IMASK), 1, 1);
		for (int k = 1; k <= 4; k++) begin
			xfer(0, 1);
			chk(irq, k == 2);
			if (k == 2) begin
				bus(ga(dmacc_pkg::G_IMASK), 1, 0);
				@(posedge clk);
				chk(irq, 1'b0);
				bus(ga(dmacc_pkg::G_IMASK), 1, 1);
				bus(ga(dmacc_pkg::G_IST), 1, 1);
				@(posedge clk);
				chk(irq, 1'b0);
			end
		end
		// Ping-pong, continuous then one-shot
		for (int m = 2; m < 4; m++) begin
			sb = sa ^ 16'h0400;
			setup(0, 16'h8010 | 16'(m), sa, sb, 16'h0);
			for (int k = 0; k < 5 - m; k++) begin
				xfer(0, 1);
				chk(wa[$], k[0] ? sb : sa);
			end
			bus(ra(0, dmacc_pkg::R_CTRL), 0, 0);
			chk(rdv[15], m == 2);
			bus(ra(0, dmacc_pkg::R_STAT), 0, 0);
			chk(rdv, m == 2 ? 32'h2 : 32'h0);
		end
		// Simultaneous peripheral requests
		setup(0, 16'h8010, sa, 16'h0, 16'h0);
		setup(1, 16'h8010, sb, 16'h0, 16'h0);
		n = wa.size();
		per_req <= 2'b11;
		@(posedge clk);
		per_req <= 2'b00;
		repeat (30) if (wa.size() < n + 2) @(posedge clk);
		chk(wa[n], sa);
		chk(wa[n + 1], sb);
		end_of_test();
	end
endmodule
`default_nettype wire
